//--- hw/touch_adc_cycle.sv
// serial conversion sequencing and touch alert for the touch converter
// Notes on behaviour
// - overlapped 12-bit words give one conversion per 15 clocks
// - three acquire clocks, twelve convert and shift
// - mode bit one selects 8-bit resolution
// - 8-bit conversion ends four clocks earlier
// - alert pin only pulls low, else released
// - armed alert pulls low while screen touched
// - alert may stay armed through power-down
// - alert armed after power-up reset
// - start bit disarms the alert
// - held low alert released at fourth falling edge
// - that release does not rearm touch detection
// - rearm from new power-down bits after conversion
// - overlapped starts keep alert disarmed continuously
// - first conversion after power-up is valid
// - power-down field selects sleep and alert arming
// - control word loads only after a start bit
// - power-down bits take effect at conversion end
// - start ignored seven clocks (12-bit) or three (8-bit)
module touch_adc_cycle
    import touch_adc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic serialShiftClock,
    input wire logic chipSelectN,
    input wire logic serialDataIn,
    input wire logic touchDetect,
    input wire logic [SAMPLE_W-1:0] sampleValue,
    output logic serialDataOut,
    output logic convBusy,
    output logic touchAlertNOut,
    output logic touchAlertNOeN,
    output logic analogPowered
);

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    // a raised select ends the frame; event toggles only see rst_b so
    // that an aborted frame never fakes an event on the core side
    logic linkRstN;
    assign linkRstN = rst_b & ~chipSelectN;

    logic [SAMPLE_W-1:0] sampleSync;
    sync_two_ff #(.WIDTH(SAMPLE_W)) uSampleSync (
        .clk(serialShiftClock),
        .rstN(rst_b),
        .din(sampleValue),
        .dout(sampleSync)
    );

    linkState_e linkState_q;
    logic [2:0] cmdCnt_q;
    logic [5:0] cmdShift_q;
    logic [2:0] holdCnt_q;
    logic convActive_q;
    logic [3:0] convCnt_q;
    logic mode8_q;
    logic [1:0] pdWord_q;
    logic [SAMPLE_W-1:0] result_q;
    logic startSince_q;
    logic startTgl_q;
    logic releaseTgl_q;
    logic doneTgl_q;
    logic doneArm_q;
    logic doneKeepOn_q;

    logic startDet;
    logic wordDone;
    logic [7:0] nextWord;
    logic convEnd;

    assign startDet = (linkState_q == HUNT) && serialDataIn;
    assign wordDone = (linkState_q == SHIFT_CMD) && (cmdCnt_q == CMD_LAST);
    assign nextWord = {1'b1, cmdShift_q, serialDataIn};
    assign convEnd = convActive_q && (convCnt_q == (mode8_q ? CONV_8 : CONV_12));

    sequence wordTwelve;
        wordDone && !nextWord[CW_MODE];
    endsequence

    sequence wordEight;
        wordDone && nextWord[CW_MODE];
    endsequence

    always_ff @(posedge serialShiftClock or negedge linkRstN) begin
        if (!linkRstN) begin
            linkState_q <= HUNT;
            cmdCnt_q <= '0;
            cmdShift_q <= '0;
            holdCnt_q <= '0;
        end else begin
            case (linkState_q)
                HUNT: begin
                    if (serialDataIn) begin
                        linkState_q <= SHIFT_CMD;
                        cmdCnt_q <= '0;
                    end
                end
                SHIFT_CMD: begin
                    cmdShift_q <= {cmdShift_q[4:0], serialDataIn};
                    cmdCnt_q <= cmdCnt_q + 3'h1;
                    if (cmdCnt_q == CMD_LAST) begin
                        linkState_q <= HOLDOFF;
                        holdCnt_q <= nextWord[CW_MODE] ? HOLD_8 : HOLD_12;
                    end
                end
                HOLDOFF: begin
                    holdCnt_q <= holdCnt_q - 3'h1;
                    if (holdCnt_q == HOLD_LAST) begin
                        linkState_q <= HUNT;
                    end
                end
                default: begin
                    linkState_q <= HUNT;
                end
            endcase
        end
    end

    // holdoff refuses starts; an early start would cut the result short
    holdTwelve_a: assert property (@(posedge serialShiftClock) disable iff (!linkRstN)
        wordTwelve |=> (!startDet) [*7]) else $error("start taken inside 12-bit holdoff");
    holdEight_a: assert property (@(posedge serialShiftClock) disable iff (!linkRstN)
        wordEight |=> (!startDet) [*3]) else $error("start taken inside 8-bit holdoff");

    // no warm-up: every word samples at once
    always_ff @(posedge serialShiftClock or negedge linkRstN) begin
        if (!linkRstN) begin
            convActive_q <= 1'b0;
            convCnt_q <= '0;
            mode8_q <= 1'b0;
            result_q <= '0;
        end else if (wordDone) begin
            convActive_q <= 1'b1;
            convCnt_q <= '0;
            mode8_q <= nextWord[CW_MODE];
            result_q <= sampleSync;
        end else if (convActive_q) begin
            convCnt_q <= convCnt_q + 4'h1;
            if (convEnd) begin
                convActive_q <= 1'b0;
            end
        end
    end

    convTwelve_a: assert property (@(posedge serialShiftClock) disable iff (!linkRstN)
        wordTwelve |-> ##13 convEnd) else $error("12-bit conversion length wrong");
    convEight_a: assert property (@(posedge serialShiftClock) disable iff (!linkRstN)
        wordEight |-> ##9 convEnd) else $error("8-bit conversion length wrong");

    // power bits load with the complete word
    always_ff @(posedge serialShiftClock or negedge rst_b) begin
        if (!rst_b) begin
            pdWord_q <= '0;
        end else if (wordDone && !chipSelectN) begin
            pdWord_q <= {nextWord[CW_PD_HI], nextWord[CW_PD_LO]};
        end
    end

    // remember a start that overlaps the conversion
    always_ff @(posedge serialShiftClock or negedge linkRstN) begin
        if (!linkRstN) begin
            startSince_q <= 1'b0;
        end else if (startDet) begin
            startSince_q <= 1'b1;
        end else if (wordDone) begin
            startSince_q <= 1'b0;
        end
    end

    overlapStart_a: assert property (@(posedge serialShiftClock) disable iff (!linkRstN)
        startDet |=> startSince_q) else $error("overlapping start not remembered");

    always_ff @(posedge serialShiftClock or negedge linkRstN) begin
        if (!linkRstN) begin
            convBusy <= 1'b0;
        end else begin
            convBusy <= wordDone;
        end
    end

    busyPulse_a: assert property (@(posedge serialShiftClock) disable iff (!linkRstN)
        wordDone |=> convBusy ##1 !convBusy) else $error("busy pulse wrong");

    always_ff @(posedge serialShiftClock or negedge rst_b) begin
        if (!rst_b) begin
            startTgl_q <= 1'b0;
        end else if (startDet && !chipSelectN) begin
            startTgl_q <= ~startTgl_q;
        end
    end

    always_ff @(posedge serialShiftClock or negedge rst_b) begin
        if (!rst_b) begin
            doneTgl_q <= 1'b0;
            doneArm_q <= 1'b0;
            doneKeepOn_q <= 1'b0;
        end else if (convEnd && !chipSelectN) begin
            doneTgl_q <= ~doneTgl_q;
            doneArm_q <= (pdWord_q[0] == PD_ALERT_ON) && !startSince_q;
            doneKeepOn_q <= (pdWord_q[1] == PD_STAY_ON);
        end
    end

    // fourth falling edge after the start bit
    always_ff @(negedge serialShiftClock or negedge rst_b) begin
        if (!rst_b) begin
            releaseTgl_q <= 1'b0;
        end else if (!chipSelectN && linkState_q == SHIFT_CMD && cmdCnt_q == RELEASE_IDX) begin
            releaseTgl_q <= ~releaseTgl_q;
        end
    end

    // msb first; 8-bit mode simply stops after the top eight bits
    always_ff @(negedge serialShiftClock or negedge linkRstN) begin
        if (!linkRstN) begin
            serialDataOut <= 1'b0;
        end else if (convActive_q && convCnt_q != 4'h0) begin
            serialDataOut <= result_q[CONV_12 - convCnt_q];
        end else begin
            serialDataOut <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // crossing into the core domain
    // ------------------------------------------------------------
    logic touchSync;
    logic [2:0] tglSync;
    logic [1:0] doneDataSync;
    logic [2:0] tglPrev_q;
    logic doneEvtD_q;
    logic startEvt;
    logic releaseEvt;
    logic doneEvt;

    sync_two_ff #(.WIDTH(1)) uTouchSync (
        .clk(core_clk),
        .rstN(rst_b),
        .din(touchDetect),
        .dout(touchSync)
    );

    sync_two_ff #(.WIDTH(3)) uTglSync (
        .clk(core_clk),
        .rstN(rst_b),
        .din({startTgl_q, releaseTgl_q, doneTgl_q}),
        .dout(tglSync)
    );

    // data bits may skew one cycle against the toggle, hence doneEvtD_q
    sync_two_ff #(.WIDTH(2)) uDoneSync (
        .clk(core_clk),
        .rstN(rst_b),
        .din({doneArm_q, doneKeepOn_q}),
        .dout(doneDataSync)
    );

    assign startEvt = tglSync[2] ^ tglPrev_q[2];
    assign releaseEvt = tglSync[1] ^ tglPrev_q[1];
    assign doneEvt = tglSync[0] ^ tglPrev_q[0];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tglPrev_q <= '0;
            doneEvtD_q <= 1'b0;
        end else begin
            tglPrev_q <= tglSync;
            doneEvtD_q <= doneEvt;
        end
    end

    // ------------------------------------------------------------
    // touch alert
    // ------------------------------------------------------------
    logic alertArmed_q;
    logic holdLow_q;

    // armed from reset; start wins over rearm
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            alertArmed_q <= 1'b1;
        end else if (startEvt) begin
            alertArmed_q <= 1'b0;
        end else if (doneEvtD_q) begin
            alertArmed_q <= doneDataSync[1];
        end
    end

    // keep a low alert until the release edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            holdLow_q <= 1'b0;
        end else if (startEvt) begin
            holdLow_q <= !touchAlertNOeN;
        end else if (releaseEvt) begin
            holdLow_q <= 1'b0;
        end
    end

    // open drain, enable low pulls the line
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            touchAlertNOeN <= 1'b1;
            touchAlertNOut <= 1'b0;
        end else begin
            touchAlertNOeN <= !((alertArmed_q && touchSync) || holdLow_q);
            touchAlertNOut <= 1'b0;
        end
    end

    // powered state follows the last completed word
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            analogPowered <= 1'b0;
        end else if (startEvt) begin
            analogPowered <= 1'b1;
        end else if (doneEvtD_q) begin
            analogPowered <= doneDataSync[0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // alert arming
    startDisarm_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        startEvt |=> !alertArmed_q) else $error("start did not disarm alert");
    releaseNoArm_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        releaseEvt |-> !alertArmed_q) else $error("alert armed at release");
    touchPull_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        alertArmed_q && touchSync |=> !touchAlertNOeN) else $error("touch not pulled low");
endmodule

//--- hw/touch_adc_pkg.sv
// shared constants and types for the touch converter control block
package touch_adc_pkg;

    // ------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 12;
    localparam int CW_MODE = 3;
    localparam int CW_PD_HI = 1;
    localparam int CW_PD_LO = 0;
    localparam logic [2:0] CMD_LAST = 3'h6;
    localparam logic [2:0] RELEASE_IDX = 3'h3;

    // ------------------------------------------------------------
    // cycle counts in serial clocks
    // ------------------------------------------------------------
    localparam logic [2:0] HOLD_12 = 3'h7;
    localparam logic [2:0] HOLD_8 = 3'h3;
    localparam logic [2:0] HOLD_LAST = 3'h1;
    localparam logic [3:0] CONV_12 = 4'hc;
    localparam logic [3:0] CONV_8 = 4'h8;

    // ------------------------------------------------------------
    // power-down field: low bit set means alert disabled
    // ------------------------------------------------------------
    localparam logic PD_ALERT_ON = 1'b0;
    localparam logic PD_STAY_ON = 1'b1;

    typedef enum logic [1:0] {
        HUNT,
        SHIFT_CMD,
        HOLDOFF
    } linkState_e;

endpackage

//--- hw/sync_two_ff.sv
// two flip-flop synchroniser for levels
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            stage1_q <= '0;
            dout <= '0;
        end else begin
            stage1_q <= din;
            dout <= stage1_q;
        end
    end
endmodule

//--- verification/host_link_model.sv
// host side serial master that clocks control words and collects result bits
module host_link_model (
    output logic serialShiftClock,
    output logic chipSelectN,
    output logic serialDataIn,
    input wire logic serialDataOut
);
    timeunit 1ns;
    timeprecision 100ps;

    logic rx[$];
    int fallCount;

    initial begin
        serialShiftClock = 1'b0;
        chipSelectN = 1'b1;
        serialDataIn = 1'b0;
        fallCount = 0;
    end

    // ------------------------------------------------------------
    // one framed burst, clock still outside it
    // ------------------------------------------------------------
    // overlapped control words
    task automatic stream(input logic [7:0] cw, input int n, input int p);
        int k;
        rx.delete();
        fallCount = 0;
        chipSelectN = 1'b0;
        #4.3;
        for (k = 0; k < (n - 1) * p + 24; k++) begin
            serialDataIn = (k % p < 8 && k / p < n) ? cw[7 - k % p] : 1'b0;
            #7.5 serialShiftClock = 1'b1;
            rx.push_back(serialDataOut);
            #7.5 serialShiftClock = 1'b0;
            fallCount++;
        end
        #4.3 chipSelectN = 1'b1;
        // released line shows the opposite level, never a held value
        serialDataIn = ~serialDataIn;
    endtask
endmodule

//--- verification/touch_adc_cycle_and_pen_alert_test.sv
// self-checking bench for conversion sequencing and the touch alert
module touch_adc_cycle_and_pen_alert_test import touch_adc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(nm, ev, sv) begin nCompared++; if ((sv) !== (ev)) begin miscompares++; \
        $display("wrong value %s expected %0h seen %0h", nm, ev, sv); end end

    logic core_clk, rst_b, touchDetect, held, watchOn;
    logic serialShiftClock, chipSelectN, serialDataIn, serialDataOut, convBusy;
    logic touchAlertNOut, touchAlertNOeN, analogPowered;
    logic [SAMPLE_W-1:0] sampleValue;
    logic [31:0] lfsrQ;
    logic expQ[$];
    int miscompares, nCompared, busyCount, lowSeen, cycles, watchEnd, k;
    // pull-up resolves the open-drain line
    wire touchAlertN = touchAlertNOeN ? 1'b1 : touchAlertNOut;

    touch_adc_cycle i_touch_adc_cycle (.core_clk, .rst_b, .serialShiftClock, .chipSelectN,
        .serialDataIn, .touchDetect, .sampleValue, .serialDataOut, .convBusy,
        .touchAlertNOut, .touchAlertNOeN, .analogPowered);
    host_link_model i_host_link_model (.serialShiftClock, .chipSelectN, .serialDataIn,
        .serialDataOut);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge convBusy) busyCount++;

    // alert watch during overlap, plus hang guard
    always @(negedge core_clk) begin
        cycles++;
        if (watchOn && i_host_link_model.fallCount >= 8
            && i_host_link_model.fallCount < watchEnd && touchAlertN !== 1'b1) lowSeen++;
        if (cycles == 8000) begin
            miscompares++;
            results();
        end
    end

    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic results();
        $display("compared %0d miscompares %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // one burst against the integer reference
    // ------------------------------------------------------------
    task automatic runTest(input logic [7:0] cw, input int n, input int p, input logic touch);
        int s;
        int lastW;
        int hold;
        int acc;
        int b;
        @(negedge core_clk);
        lfsrQ = lfsrNext(lfsrQ);
        sampleValue = lfsrQ[SAMPLE_W-1:0];
        touchDetect = touch;
        repeat (10) @(negedge core_clk);
        held = touchAlertN;
        busyCount = 0;
        lowSeen = 0;
        // watch stops where the last conversion ends and rearming is legal
        watchEnd = (n - 1) * p + (cw[3] ? 16 : 20);
        watchOn = cw[7];
        fork
            i_host_link_model.stream(cw, n, p);
            begin
                wait (i_host_link_model.fallCount == 3);
                `CHK("alert at start", held, touchAlertN)
                wait (i_host_link_model.fallCount == 7);
                `CHK("alert released", cw[7] | held, touchAlertN)
                wait (i_host_link_model.fallCount == 15);
                `CHK("alert disarmed", cw[7] | held, touchAlertN)
            end
        join
        watchOn = 1'b0;
        repeat (10) @(negedge core_clk);
        expQ = {};
        for (b = 0; b < (n - 1) * p + 24; b++) expQ.push_back(1'b0);
        lastW = -100;
        hold = 0;
        acc = 0;
        // start refused inside the hold-off after a word
        for (s = 0; s < n * p; s += p) begin
            if (cw[7] && s - lastW >= hold) begin
                acc++;
                lastW = s + 7;
                hold = cw[3] ? 4 : 8;
                for (b = 0; b < (cw[3] ? 8 : 12); b++) expQ[s + 9 + b] = sampleValue[11 - b];
            end
        end
        for (b = 0; b < expQ.size(); b++)
            `CHK("result bit", expQ[b], i_host_link_model.rx[b])
        `CHK("conversions", acc, busyCount)
        `CHK("alert in overlap", 0, lowSeen)
        if (cw[7]) begin
            `CHK("alert after end", ~(touch & ~cw[0]), touchAlertN)
            `CHK("power state", cw[1], analogPowered)
        end
        $display("test done cw %0h", cw);
    endtask

    initial begin
        rst_b = 1'b0;
        touchDetect = 1'b0;
        sampleValue = 12'h000;
        lfsrQ = 32'ha5fd;
        cycles = 0;
        miscompares = 0;
        nCompared = 0;
        watchOn = 1'b0;
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        `CHK("idle alert", 1'b1, touchAlertN)
        touchDetect = 1'b1;
        @(negedge core_clk);
        `CHK("alert before sync", 1'b1, touchAlertN)
        for (k = 0; k < 8 && touchAlertN !== 1'b0; k++) @(negedge core_clk);
        `CHK("armed alert", 1'b0, touchAlertN)
        `CHK("open drain data", 1'b0, touchAlertNOut)
        $display("test done alert arm");
        runTest(8'h80, 1, 15, 1'b1);
        runTest(8'h92, 4, 15, 1'b1);
        runTest(8'h9b, 4, 11, 1'b1);
        runTest(8'h89, 3, 12, 1'b1);
        runTest(8'he0, 3, 12, 1'b0);
        runTest(8'h00, 1, 15, 1'b1);
        runTest(8'h9c, 2, 15, 1'b1);
        results();
    end
endmodule
